// [src/sil_pkg.sv]
package sil_pkg;
    // Register byte addresses
    localparam logic [15:0] ADDR_INT_ONE   = 16'hff04;
    localparam logic [15:0] ADDR_INT_TWO   = 16'hff08;
    localparam logic [15:0] ADDR_INT_THREE = 16'hff0c;
    localparam logic [15:0] ADDR_CONFIG    = 16'hff10;
    localparam logic [15:0] ADDR_BRK_FLAG  = 16'hff14;
    // Source indices, highest hardware priority first
    localparam int SRC_EXT = 0;
    localparam int SRC_CH0 = 1;
    localparam int SRC_CH1 = 2;
    localparam int SRC_OVF = 3;
    localparam int SRC_KBD = 4;
    localparam int SRC_ADC = 5;
    localparam int NUM_SRC = 6;
    // Status bit positions
    localparam int BIT_EXT = 2;
    localparam int BIT_CH0 = 4;
    localparam int BIT_CH1 = 5;
    localparam int BIT_OVF = 6;
    localparam int BIT_KBD = 7;
    localparam int BIT_ADC = 0;
    // Control and break status bit positions
    localparam int BIT_SHORT_REC = 0;
    localparam int BIT_WDOG_DIS  = 1;
    localparam int BIT_BREAK_STOP_WAIT_STATUS      = 1;
    localparam int BIT_BREAK_CLEAR_ENABLE      = 7;
    // Vector addresses
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_SWI   = 16'hfffc;
    localparam logic [15:0] VEC_EXT   = 16'hfffa;
    localparam logic [15:0] VEC_CH0   = 16'hfff6;
    localparam logic [15:0] VEC_CH1   = 16'hfff4;
    localparam logic [15:0] VEC_OVF   = 16'hfff2;
    localparam logic [15:0] VEC_KBD   = 16'hffe0;
    localparam logic [15:0] VEC_ADC   = 16'hffde;
    // Stop recovery lengths in four-times bus clock cycles
    localparam int REC_LONG  = 4096;
    localparam int REC_SHORT = 32;
    typedef enum logic [2:0] {
        ST_RUN     = 3'b000,
        ST_WAIT    = 3'b001,
        ST_STOP    = 3'b010,
        ST_RECOVER = 3'b011,
        ST_STACK   = 3'b100
    } sil_state_t;
endpackage

// [src/recovery_if.sv]
interface recovery_if;
    logic hold;       // Counter held cleared
    logic short_sel;  // Short recovery selected
    logic done;       // Recovery time elapsed
    modport ctl (output hold, output short_sel, input done);
    modport cnt (input hold, input short_sel, output done);
endinterface

// [src/recovery_counter.sv]
module recovery_counter
    import sil_pkg::*;
#(
    parameter int LONG_CYCLES  = REC_LONG,
    parameter int SHORT_CYCLES = REC_SHORT
)(
    input  wire logic  i_clk,    // Four-times bus clock
    input  wire logic  i_resetn, // Async reset, active low
    recovery_if.cnt    rif       // Hold, select and done
);
    localparam int W = $clog2(LONG_CYCLES) + 1;
    logic [W-1:0] count_q;
    logic [W-1:0] last;

    // Terminal count for the selected recovery
    assign last = rif.short_sel ? W'(SHORT_CYCLES - 1)
                                : W'(LONG_CYCLES - 1);

    // Counter advances on the falling edge, cleared while held
    always_ff @(negedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            count_q  <= '0;
            rif.done <= 1'b0;
        end
        else if (rif.hold)
        begin
            count_q  <= '0;
            rif.done <= 1'b0;
        end
        else if (count_q == last)
            rif.done <= 1'b1;
        else
            count_q <= count_q + W'(1);
    end
endmodule

// [src/system_interrupt_and_low_power_control.sv]
// The APB slave port is this design's own decision.
module system_interrupt_and_low_power_control
    import sil_pkg::*;
#(
    parameter int LONG_CYCLES  = REC_LONG,
    parameter int SHORT_CYCLES = REC_SHORT
)(
    input  wire logic                i_clk,          // Four-times bus clock
    input  wire logic                i_resetn,       // Async reset, low
    input  wire logic                i_psel,         // APB select
    input  wire logic                i_penable,      // APB enable
    input  wire logic                i_pwrite,       // APB direction
    input  wire logic [15:0]         i_paddr,        // APB address
    input  wire logic [31:0]         i_pwdata,       // APB write data
    output logic      [31:0]         o_prdata,       // APB read data
    output logic                     o_pready,       // APB ready
    output logic                     o_pslverr,      // APB error
    input  wire logic                i_instr_done,   // Instruction boundary
    input  wire logic                i_cpu_ext_pin_irq_mask,    // Global mask bit
    input  wire logic                i_swi_exec,     // Software interrupt
    input  wire logic                i_wait_exec,    // Wait executed
    input  wire logic                i_stop_exec,    // Stop executed
    input  wire logic                i_return_done,  // Return completed
    input  wire logic                i_reset_req,    // Any reset source
    input  wire logic                i_break_req,    // Break request
    input  wire logic [NUM_SRC-1:0]  i_src_flag,     // Source flags
    input  wire logic [NUM_SRC-1:0]  i_src_enable,   // Source enables
    output logic                     o_int_start,    // Stacking pulse
    output logic      [15:0]         o_vector,       // Vector to fetch
    output logic                     o_push_pc_dec,  // Stack PC minus one
    output logic                     o_push_idx_hi,  // Stack high index
    output logic                     o_clear_ext_pin_irq_mask,  // Clear mask pulse
    output logic                     o_cpu_clk_en,   // CPU clocks on
    output logic                     o_periph_clk_en,// Peripheral clocks
    output logic                     o_osc_en,       // Oscillator outputs
    output logic                     o_watchdog_run, // Watchdog active
    output logic                     o_clear_allow,  // Flag clear allowed
    output logic                     o_cpu_reset     // Reset vector pulse
);
    sil_state_t           state_q;
    sil_state_t           state_d;
    logic [NUM_SRC-1:0]   pend;
    logic                 hw_req;
    logic [15:0]          hw_vec;
    logic                 take_d;
    logic [15:0]          vec_d;
    logic                 dec_d;
    logic                 brk_take_d;
    logic                 clr_mask_d;
    logic                 short_rec_q;
    logic                 wdog_dis_q;
    logic                 break_clear_enable_q;
    logic                 break_stop_wait_status_q;
    logic                 break_mode_q;
    logic                 wr_en;
    logic                 rd_en;
    logic [7:0]           int_one;
    logic [7:0]           int_two;
    logic [7:0]           int_three;
    logic [31:0]          rd_data;
    logic                 rd_hit;
    logic [15:0]          rec_cyc_q;
    recovery_if           rif ();

    // Sources with a request present and enabled
    assign pend   = i_src_flag & i_src_enable;
    assign hw_req = |pend;

    // Fixed priority pick among hardware sources
    always_comb
    begin
        hw_vec = VEC_ADC;
        if (pend[SRC_EXT])
            hw_vec = VEC_EXT;
        else if (pend[SRC_CH0])
            hw_vec = VEC_CH0;
        else if (pend[SRC_CH1])
            hw_vec = VEC_CH1;
        else if (pend[SRC_OVF])
            hw_vec = VEC_OVF;
        else if (pend[SRC_KBD])
            hw_vec = VEC_KBD;
    end

    // Sequencing of boundaries, low-power modes and wake-up
    always_comb
    begin
        state_d    = state_q;
        take_d     = 1'b0;
        vec_d      = VEC_SWI;
        dec_d      = 1'b0;
        brk_take_d = 1'b0;
        clr_mask_d = 1'b0;
        case (state_q)
            ST_RUN:
            begin
                if (i_instr_done)
                begin
                    if (i_break_req)
                    begin
                        take_d     = 1'b1;
                        brk_take_d = 1'b1;
                    end
                    else if (i_swi_exec)
                        take_d = 1'b1;
                    else if (i_wait_exec)
                    begin
                        state_d    = ST_WAIT;
                        clr_mask_d = 1'b1;
                    end
                    else if (i_stop_exec)
                    begin
                        state_d    = ST_STOP;
                        clr_mask_d = 1'b1;
                    end
                    else if (hw_req && !i_cpu_ext_pin_irq_mask)
                    begin
                        take_d = 1'b1;
                        vec_d  = hw_vec;
                        dec_d  = 1'b1;
                    end
                end
            end
            ST_WAIT:
            begin
                if (hw_req || i_break_req)
                    state_d = ST_STACK;
            end
            ST_STOP:
            begin
                if (hw_req || i_break_req)
                    state_d = ST_RECOVER;
            end
            ST_RECOVER:
            begin
                if (rif.done)
                    state_d = ST_STACK;
            end
            ST_STACK:
            begin
                state_d = ST_RUN;
                take_d  = 1'b1;
                if (i_break_req)
                    brk_take_d = 1'b1;
                else if (hw_req)
                begin
                    vec_d = hw_vec;
                    dec_d = 1'b1;
                end
            end
            default:
                state_d = ST_RUN;
        endcase
        if (i_reset_req)
        begin
            state_d    = ST_RUN;
            take_d     = 1'b0;
            brk_take_d = 1'b0;
            clr_mask_d = 1'b0;
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            state_q <= ST_RUN;
        else
            state_q <= state_d;
    end

    // Entry outputs: vector, stacking pulse, return address choice
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_int_start   <= 1'b0;
            o_vector      <= VEC_RESET;
            o_push_pc_dec <= 1'b0;
            o_push_idx_hi <= 1'b0;
            o_clear_ext_pin_irq_mask <= 1'b0;
            o_cpu_reset   <= 1'b0;
        end
        else
        begin
            o_int_start   <= take_d;
            o_clear_ext_pin_irq_mask <= clr_mask_d;
            o_cpu_reset   <= i_reset_req;
            o_push_idx_hi <= 1'b0;
            if (i_reset_req)
                o_vector <= VEC_RESET;
            else if (take_d)
            begin
                o_vector      <= vec_d;
                o_push_pc_dec <= dec_d;
            end
        end
    end

    // Clock gating and watchdog activity from the next state
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_cpu_clk_en    <= 1'b1;
            o_periph_clk_en <= 1'b1;
            o_osc_en        <= 1'b1;
            o_watchdog_run  <= 1'b0;
        end
        else
        begin
            o_cpu_clk_en    <= (state_d == ST_RUN)
                            || (state_d == ST_STACK);
            o_periph_clk_en <= (state_d != ST_STOP)
                            && (state_d != ST_RECOVER);
            o_osc_en        <= (state_d != ST_STOP);
            o_watchdog_run  <= !wdog_dis_q
                            && (state_d != ST_STOP)
                            && (state_d != ST_RECOVER);
        end
    end

    // Break mode tracking and flag clear permission
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            break_mode_q  <= 1'b0;
            o_clear_allow <= 1'b1;
        end
        else
        begin
            if (brk_take_d)
                break_mode_q <= 1'b1;
            else if (i_return_done || i_reset_req)
                break_mode_q <= 1'b0;
            // Unless break_clear_enable_q is set, blocks every clearing step from break entry until i_return_done ends break mode
            o_clear_allow <= break_clear_enable_q
                          || !(brk_take_d
                          || (break_mode_q && !i_return_done));
        end
    end

    // Stop recovery counter control
    assign rif.hold      = (state_q != ST_RECOVER);
    assign rif.short_sel = short_rec_q;

    recovery_counter #(
        .LONG_CYCLES  (LONG_CYCLES),
        .SHORT_CYCLES (SHORT_CYCLES)
    ) u_rec (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .rif      (rif)
    );

    // Status register images
    always_comb
    begin
        int_one            = 8'h00;
        int_two            = 8'h00;
        int_three          = 8'h00;
        int_one[BIT_EXT]   = pend[SRC_EXT];
        int_one[BIT_CH0]   = pend[SRC_CH0];
        int_one[BIT_CH1]   = pend[SRC_CH1];
        int_one[BIT_OVF]   = pend[SRC_OVF];
        int_two[BIT_KBD]   = pend[SRC_KBD];
        int_three[BIT_ADC] = pend[SRC_ADC];
    end

    // APB read decode
    always_comb
    begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (i_paddr)
            ADDR_INT_ONE:   rd_data[7:0] = int_one;
            ADDR_INT_TWO:   rd_data[7:0] = int_two;
            ADDR_INT_THREE: rd_data[7:0] = int_three;
            ADDR_CONFIG:
            begin
                rd_data[BIT_SHORT_REC] = short_rec_q;
                rd_data[BIT_WDOG_DIS]  = wdog_dis_q;
            end
            ADDR_BRK_FLAG:
            begin
                rd_data[BIT_BREAK_STOP_WAIT_STATUS] = break_stop_wait_status_q;
                rd_data[BIT_BREAK_CLEAR_ENABLE] = break_clear_enable_q;
            end
            default:        rd_hit = 1'b0;
        endcase
    end

    assign rd_en = i_psel && i_penable && !o_pready;
    assign wr_en = i_psel && i_penable && o_pready && i_pwrite;

    // APB answer: ready in the second access cycle
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end
        else
        begin
            o_pready  <= rd_en;
            o_pslverr <= rd_en && !rd_hit;
            o_prdata  <= (rd_en && !i_pwrite) ? rd_data : 32'h0000_0000;
        end
    end

    // Writable control bits; status images ignore writes
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            short_rec_q <= 1'b0;
            wdog_dis_q  <= 1'b0;
            break_clear_enable_q      <= 1'b0;
        end
        else if (wr_en && i_paddr == ADDR_CONFIG)
        begin
            short_rec_q <= i_pwdata[BIT_SHORT_REC];
            wdog_dis_q  <= i_pwdata[BIT_WDOG_DIS];
        end
        else if (wr_en && i_paddr == ADDR_BRK_FLAG)
            break_clear_enable_q <= i_pwdata[BIT_BREAK_CLEAR_ENABLE];
    end

    // Break during wait status, set wins over write-one clear
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            break_stop_wait_status_q <= 1'b0;
        else if (state_q == ST_WAIT && i_break_req)
            break_stop_wait_status_q <= 1'b1;
        else if (wr_en && i_paddr == ADDR_BRK_FLAG
                 && i_pwdata[BIT_BREAK_STOP_WAIT_STATUS])
            break_stop_wait_status_q <= 1'b0;
    end

    // Helper: posedges spent in recovery
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            rec_cyc_q <= 16'h0000;
        else if (state_q == ST_RECOVER)
            rec_cyc_q <= rec_cyc_q + 16'h0001;
        else
            rec_cyc_q <= 16'h0000;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    property p_boundary;
        o_int_start |-> $past(i_instr_done || state_q == ST_STACK);
    endproperty
    a_boundary: assert property (p_boundary)
        else $error("interrupt started off a boundary");

    property p_masked;
        state_q == ST_RUN && i_instr_done && i_cpu_ext_pin_irq_mask && !i_swi_exec
        && !i_break_req && !i_reset_req |=> !o_int_start;
    endproperty
    a_masked: assert property (p_masked)
        else $error("masked interrupt was taken");

    property p_swi;
        state_q == ST_RUN && i_instr_done && i_swi_exec && !i_break_req
        && !i_reset_req |=> o_int_start && o_vector == VEC_SWI
        && !o_push_pc_dec;
    endproperty
    a_swi: assert property (p_swi)
        else $error("software interrupt not taken");

    property p_prio;
        state_q == ST_RUN && i_instr_done && !i_cpu_ext_pin_irq_mask && pend[SRC_EXT]
        && !i_swi_exec && !i_break_req && !i_wait_exec && !i_stop_exec
        && !i_reset_req |=> o_vector == VEC_EXT && o_push_pc_dec;
    endproperty
    a_prio: assert property (p_prio)
        else $error("wrong priority or return address");

    property p_wait_entry;
        state_q == ST_RUN && i_instr_done && i_wait_exec && !i_swi_exec
        && !i_break_req && !i_reset_req
        |=> o_clear_ext_pin_irq_mask && !o_cpu_clk_en && o_periph_clk_en;
    endproperty
    a_wait_entry: assert property (p_wait_entry)
        else $error("wait entry wrong");

    property p_wait_wake;
        state_q == ST_WAIT && hw_req && !i_reset_req && !i_break_req
        ##1 !i_reset_req |=> o_int_start && o_push_pc_dec;
    endproperty
    a_wait_wake: assert property (p_wait_wake)
        else $error("wait wake stacking late");

    property p_break_stop_wait_status;
        state_q == ST_WAIT && i_break_req |=> break_stop_wait_status_q;
    endproperty
    a_break_stop_wait_status: assert property (p_break_stop_wait_status)
        else $error("break in wait did not set status");

    property p_stop_osc;
        state_q == ST_STOP && $past(state_q == ST_STOP)
        |-> !o_osc_en && !o_cpu_clk_en && !o_periph_clk_en;
    endproperty
    a_stop_osc: assert property (p_stop_osc)
        else $error("clocks running in stop");

    property p_rec_min;
        state_q == ST_RECOVER && rif.done
        |-> rec_cyc_q >= (short_rec_q ? 16'(SHORT_CYCLES - 1)
                                      : 16'(LONG_CYCLES - 1));
    endproperty
    a_rec_min: assert property (p_rec_min)
        else $error("stop recovery too short");

    property p_rec_max;
        state_q == ST_RECOVER
        |-> rec_cyc_q <= (short_rec_q ? 16'(SHORT_CYCLES + 2)
                                      : 16'(LONG_CYCLES + 2));
    endproperty
    a_rec_max: assert property (p_rec_max)
        else $error("stop recovery too long");

    property p_protect;
        break_mode_q && !break_clear_enable_q && !i_return_done |=> !o_clear_allow;
    endproperty
    a_protect: assert property (p_protect)
        else $error("flag clear allowed in break");

    property p_int_one;
        o_pready && !o_pslverr && $past(i_paddr == ADDR_INT_ONE)
        |-> (o_prdata[31:0] & ~32'h0000_0074) == 32'h0000_0000;
    endproperty
    a_int_one: assert property (p_int_one)
        else $error("reserved status bits set");
endmodule

// [verification/cpu_model.sv]
module cpu_model (
    input  wire logic       i_clk,  // Four-times bus clock
    input  wire logic       i_run,  // CPU clocks enabled
    input  wire logic       i_go,   // Finish the current instruction
    input  wire logic [1:0] i_kind, // 1 swi, 2 wait, 3 stop
    output logic            o_done, // Boundary pulse
    output logic            o_swi,  // Software interrupt executed
    output logic            o_wait, // Wait executed
    output logic            o_stop  // Stop executed
);
    timeunit 1ns;
    timeprecision 1ns;
    // Quiet start
    initial
    begin
        o_done = 1'b0;
        o_swi = 1'b0;
        o_wait = 1'b0;
        o_stop = 1'b0;
    end
    // Boundary only with clocks; qualifiers are junk between boundaries
    always @(posedge i_clk)
    begin
        o_done <= i_go && i_run;
        if (i_go && i_run)
        begin
            o_swi <= i_kind == 2'd1;
            o_wait <= i_kind == 2'd2;
            o_stop <= i_kind == 2'd3;
        end
        else
        begin
            o_swi <= ~o_swi;
            o_wait <= ~o_wait;
            o_stop <= ~o_stop;
        end
    end
endmodule

// [verification/system_interrupt_and_low_power_control_tb_top.sv]
`define CHK(nm, e, g) \
    begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module system_interrupt_and_low_power_control_tb_top;
    import sil_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LC = 64;
    localparam int SC = 8;
    logic        i_clk, i_resetn, i_psel, i_penable, i_pwrite, go, err;
    logic        i_cpu_ext_pin_irq_mask, i_return_done, i_reset_req, i_break_req;
    logic        i_instr_done, i_swi_exec, i_wait_exec, i_stop_exec;
    logic        o_pready, o_pslverr, o_int_start, o_push_pc_dec;
    logic        o_push_idx_hi, o_clear_ext_pin_irq_mask, o_cpu_clk_en, o_cpu_reset;
    logic        o_periph_clk_en, o_osc_en, o_watchdog_run, o_clear_allow;
    logic [1:0]  kind;
    logic [15:0] i_paddr, o_vector;
    logic [31:0] i_pwdata, o_prdata, rd;
    logic [5:0]  i_src_flag, i_src_enable;
    logic [15:0] vtab [6];
    int          bad_count, n_compared, n, i;

    always #2 i_clk = ~i_clk;

    system_interrupt_and_low_power_control #(
        .LONG_CYCLES(LC), .SHORT_CYCLES(SC)) dut (
        .i_clk, .i_resetn, .i_psel, .i_penable, .i_pwrite, .i_paddr,
        .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_instr_done,
        .i_cpu_ext_pin_irq_mask, .i_swi_exec, .i_wait_exec, .i_stop_exec,
        .i_return_done, .i_reset_req, .i_break_req, .i_src_flag,
        .i_src_enable, .o_int_start, .o_vector, .o_push_pc_dec,
        .o_push_idx_hi, .o_clear_ext_pin_irq_mask, .o_cpu_clk_en, .o_periph_clk_en,
        .o_osc_en, .o_watchdog_run, .o_clear_allow, .o_cpu_reset);
    cpu_model cpu (.i_clk, .i_run(o_cpu_clk_en), .i_go(go), .i_kind(kind),
        .o_done(i_instr_done), .o_swi(i_swi_exec), .o_wait(i_wait_exec),
        .o_stop(i_stop_exec));

    task automatic test_done();
        if (bad_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // One APB transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        int t;
        t = 0;
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1 && ++t < 50);
        if (o_pready !== 1'b1)
            bad_count++;
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("read", {24'h0, e}, rd)
    endtask
    task automatic bnd(input logic [1:0] k);
        go <= 1'b1;
        kind <= k;
        @(posedge i_clk);
        go <= 1'b0;
    endtask
    // Count cycles until stacking starts, bounded by lim
    task automatic await(input int lim);
        n = 0;
        do @(negedge i_clk); while (o_int_start !== 1'b1 && ++n < lim);
        @(posedge i_clk);
    endtask

    initial
    begin
        i_clk = 0;
        {i_resetn, i_psel, i_penable, i_pwrite, go, kind} = '0;
        {i_cpu_ext_pin_irq_mask, i_return_done, i_reset_req, i_break_req} = '0;
        {i_paddr, i_pwdata, i_src_flag, i_src_enable} = '0;
        bad_count = 0;
        n_compared = 0;
        vtab = '{VEC_EXT, VEC_CH0, VEC_CH1, VEC_OVF, VEC_KBD, VEC_ADC};
        repeat (16) @(posedge i_clk);
        `CHK("vector", VEC_RESET, o_vector)
        i_resetn <= 1'b1;
        @(posedge i_clk);
        i_src_flag <= 6'h3f;
        i_src_enable <= 6'h3f;
        @(negedge i_clk);
        `CHK("wdog", 1'b1, o_watchdog_run)
        @(posedge i_clk);
        apb(1'b1, ADDR_INT_ONE, 32'hff);
        rchk(ADDR_INT_ONE, 8'h74);
        rchk(ADDR_INT_TWO, 8'h80);
        rchk(ADDR_INT_THREE, 8'h01);
        i_src_enable <= 6'h0a;
        rchk(ADDR_INT_ONE, 8'h50);
        apb(1'b0, 16'hff00, 32'h0);
        `CHK("slverr", 1'b1, err)
        i_src_enable <= 6'h3f;
        for (i = 0; i < 6; i++)
        begin
            i_src_flag <= 6'h3f << i;
            bnd(2'd0);
            await(20);
            `CHK("vector", vtab[i], o_vector)
            `CHK("pcdec", 1'b1, o_push_pc_dec)
            `CHK("idxhi", 1'b0, o_push_idx_hi)
        end
        await(8);
        `CHK("noboundary", 8, n)
        i_cpu_ext_pin_irq_mask <= 1'b1;
        bnd(2'd0);
        await(8);
        `CHK("masked", 8, n)
        i_cpu_ext_pin_irq_mask <= 1'b0;
        i_src_enable <= 6'h00;
        bnd(2'd0);
        await(8);
        `CHK("disabled", 8, n)
        i_cpu_ext_pin_irq_mask <= 1'b1;
        bnd(2'd1);
        await(20);
        `CHK("vector", VEC_SWI, o_vector)
        `CHK("pcdec", 1'b0, o_push_pc_dec)
        i_cpu_ext_pin_irq_mask <= 1'b0;
        i_src_flag <= 6'h00;
        i_src_enable <= 6'h3f;
        for (i = 0; i < 2; i++)
        begin
            i_break_req <= 1'b1;
            bnd(2'd0);
            await(20);
            i_break_req <= 1'b0;
            `CHK("vector", VEC_SWI, o_vector)
            `CHK("clrallow", 1'(i), o_clear_allow)
            i_return_done <= 1'b1;
            @(posedge i_clk);
            i_return_done <= 1'b0;
            repeat (2) @(negedge i_clk);
            `CHK("clrallow", 1'b1, o_clear_allow)
            @(posedge i_clk);
            apb(1'b1, ADDR_BRK_FLAG, 32'h80);
        end
        rchk(ADDR_BRK_FLAG, 8'h80);
        apb(1'b1, ADDR_BRK_FLAG, 32'h00);
        bnd(2'd2);
        repeat (2) @(negedge i_clk);
        `CHK("clrmask", 1'b1, o_clear_ext_pin_irq_mask)
        `CHK("cpuclk", 1'b0, o_cpu_clk_en)
        `CHK("perclk", 1'b1, o_periph_clk_en)
        `CHK("wdog", 1'b1, o_watchdog_run)
        @(posedge i_clk);
        i_src_flag <= 6'h01;
        await(20);
        `CHK("waitwake", 2, n)
        i_src_flag <= 6'h00;
        bnd(2'd2);
        repeat (3) @(posedge i_clk);
        i_break_req <= 1'b1;
        await(20);
        i_break_req <= 1'b0;
        rchk(ADDR_BRK_FLAG, 8'h02);
        apb(1'b1, ADDR_CONFIG, 32'h02);
        @(negedge i_clk);
        `CHK("wdog", 1'b0, o_watchdog_run)
        for (i = 0; i < 2; i++)
        begin
            @(posedge i_clk);
            apb(1'b1, ADDR_CONFIG, {31'h0, i == 0});
            bnd(2'd3);
            repeat (3) @(negedge i_clk);
            `CHK("osc", 1'b0, o_osc_en)
            `CHK("perclk", 1'b0, o_periph_clk_en)
            @(posedge i_clk);
            i_src_flag <= 6'h20;
            await(200);
            i_src_flag <= 6'h00;
            `CHK("recovery", 1'b1, n >= (i ? LC : SC) && n <= (i ? LC : SC) + 8)
        end
        i_reset_req <= 1'b1;
        i_src_flag <= 6'h01;
        bnd(2'd0);
        repeat (2) @(negedge i_clk);
        `CHK("cpureset", 1'b1, o_cpu_reset)
        `CHK("vector", VEC_RESET, o_vector)
        test_done();
    end

    initial
    begin
        repeat (30000) @(posedge i_clk);
        bad_count++;
        test_done();
    end
endmodule
